//--- bench/tb_cdo_clock_ctrl.sv
// Self-checking testbench for the clock doubler and output pin control block
`timescale 1ns/1ns

module tb_cdo_clock_ctrl;
   logic                  core_clk;
   logic                  reset;
   cdo_pkg::cdo_bus_req_t reg_req;
   logic [7:0]            reg_rdata;
   logic                  osc_main;
   logic                  osc_32k;
   logic                  wdt_timeout_n;
   logic                  first_fetch;
   logic                  int_ack;
   logic                  ext_io_cycle;
   logic                  data_mem_access;
   logic                  mem_wr_req;
   logic                  io_wr_req;
   logic                  proc_clk;
   logic                  peri_clk;
   logic                  clk_pin;
   logic                  status_n;
   logic                  watchdog_out_n;
   logic                  buffer_enable_n;
   logic                  mem_wr_n;
   logic                  io_wr_n;
   logic [2:0]            fetch_waits;
   logic                  main_osc_off;
   logic [7:0]            osc_cnt;
   int                    err_total;
   int                    n_compared;
   // Clock table: delay, power control, proc rises, peri rises, main stop
   logic [7:0]            t_dly [8] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
   logic [7:0]            t_pwr [8] = '{8'h08, 8'h08, 8'h28, 8'h00, 8'h04, 8'h00, 8'h10, 8'h14};
   int                    t_pr  [8] = '{80, 40, 10, 5, 5, 10, 10, 10};
   int                    t_pe  [8] = '{80, 40, 10, 5, 40, 10, 10, 10};
   logic                  t_off [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   // Code seven is still active here, so the peripheral clock is doubled
   int                    exp_cr [4] = '{80, 40, 0, 0};

   cdo_clock_ctrl cdo_clock_ctrl_inst (
      .core_clk        (core_clk),
      .reset           (reset),
      .reg_req         (reg_req),
      .reg_rdata       (reg_rdata),
      .osc_main        (osc_main),
      .osc_32k         (osc_32k),
      .wdt_timeout_n   (wdt_timeout_n),
      .first_fetch     (first_fetch),
      .int_ack         (int_ack),
      .ext_io_cycle    (ext_io_cycle),
      .data_mem_access (data_mem_access),
      .mem_wr_req      (mem_wr_req),
      .io_wr_req       (io_wr_req),
      .proc_clk        (proc_clk),
      .peri_clk        (peri_clk),
      .clk_pin         (clk_pin),
      .status_n        (status_n),
      .watchdog_out_n  (watchdog_out_n),
      .buffer_enable_n (buffer_enable_n),
      .mem_wr_n        (mem_wr_n),
      .io_wr_n         (io_wr_n),
      .fetch_waits     (fetch_waits),
      .main_osc_off    (main_osc_off)
   );

   // Core clock, 10 ns period
   always #5 core_clk = ~core_clk;

   // Oscillator stand-ins: main period 16 cycles, slow one 64 cycles, far faster than 32 kHz
   always @(posedge core_clk) begin
      osc_cnt  <= osc_cnt + 8'h01;
      osc_main <= (osc_cnt[2:0] == 3'h7) ? ~osc_main : osc_main;
      osc_32k  <= (osc_cnt[4:0] == 5'h1f) ? ~osc_32k : osc_32k;
   end

   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_cyc

   // One-cycle write strobe beside address and data
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      reg_req.wr <= 1'b0;
   endtask : wr_reg

   // Read data are only valid in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      reg_req.rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd_reg

   // Counts rising edges of the clocks and the longest low run of proc_clk
   task automatic measure(input int n, output int pr, output int pe, output int cr, output int lo);
      logic pp;
      logic pq;
      logic pc;
      int   run;
      pr = 0;
      pe = 0;
      cr = 0;
      lo = 0;
      run = 0;
      @(posedge core_clk);
      #1;
      pp = proc_clk;
      pq = peri_clk;
      pc = clk_pin;
      repeat (n) begin
         @(posedge core_clk);
         #1;
         if (proc_clk === 1'b1 && pp === 1'b0) pr++;
         if (peri_clk === 1'b1 && pq === 1'b0) pe++;
         if (clk_pin === 1'b1 && pc === 1'b0) cr++;
         run = (proc_clk === 1'b0) ? run + 1 : 0;
         lo = (run > lo) ? run : lo;
         pp = proc_clk;
         pq = peri_clk;
         pc = clk_pin;
      end
   endtask : measure

   function automatic logic near(input int s, input int e);
      return (s >= e - 1) && (s <= e + 1);
   endfunction : near

   // Hang guard, well beyond the expected run of about 20k cycles
   initial begin
      #700000;
      err_total++;
      summarize();
   end

   initial begin
      logic [7:0] d;
      int         pr;
      int         pe;
      int         cr;
      int         lo;
      int         len;
      logic       e;
      core_clk = 1'b0;
      reset = 1'b1;
      reg_req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      {osc_main, osc_32k, osc_cnt} = '0;
      {first_fetch, int_ack, ext_io_cycle, data_mem_access, mem_wr_req, io_wr_req} = '0;
      wdt_timeout_n = 1'b1;
      err_total = 0;
      n_compared = 0;
      wait_cyc(3);
      #1;
      check("reset_pins", {proc_clk, status_n, buffer_enable_n, watchdog_out_n, mem_wr_n, io_wr_n}, 6'h1f);
      check("reset_waits", {fetch_waits, main_osc_off}, 4'h0);
      // Release on the fourth edge so reset spans four cycles
      @(posedge core_clk);
      reset <= 1'b0;
      // Reset values, ignored bits and an unmapped place
      rd_reg(8'h0f, d);
      check("dly_reset", d, 8'h00);
      rd_reg(8'h0e, d);
      check("pin_sel_reset", d, 8'h00);
      rd_reg(8'h10, d);
      check("pwr_reset", d, 8'h08);
      rd_reg(8'h11, d);
      check("status_reset", d & 8'hbf, 8'h10);
      wr_reg(8'h0e, 8'h04);
      wr_reg(8'h20, 8'hff);
      rd_reg(8'h0e, d);
      check("pin_sel_bit2", d, 8'h00);
      rd_reg(8'h20, d);
      check("unmapped", d, 8'h00);
      $display("Test registers done");
      // Clock source, doubler and divider combinations
      for (int i = 0; i < 8; i++) begin
         wr_reg(8'h0f, t_dly[i]);
         wr_reg(8'h10, t_pwr[i]);
         wait_cyc(700);
         measure(640, pr, pe, cr, lo);
         check("proc_rises", near(pr, t_pr[i]), 1'b1);
         check("peri_rises", near(pe, t_pe[i]), 1'b1);
         check("main_osc_off", main_osc_off, t_off[i]);
      end
      wr_reg(8'h10, 8'h08);
      wait_cyc(700);
      $display("Test clock table done");
      // Low time per code, with the upper delay bits set to junk
      for (int c = 0; c < 8; c++) begin
         wr_reg(8'h0f, 8'hf8 | 8'(c));
         wait_cyc(300);
         rd_reg(8'h0f, d);
         check("dly_readback", d, 8'(c));
         measure(320, pr, pe, cr, lo);
         check("low_run", 16'(lo), (c == 0) ? 16'd8 : 16'((15 + 2 * c) / 10));
         check("doubled_rises", near(pr, (c == 0) ? 20 : 40), 1'b1);
      end
      $display("Test doubler codes done");
      // Fetch wait states
      for (int w = 0; w < 4; w++) begin
         wr_reg(8'h10, 8'h08 | 8'(w));
         wait_cyc(4);
         #1;
         check("fetch_waits", fetch_waits, (w == 3) ? 3'h4 : 3'(w));
      end
      // Write strobes only in the low phase of the processor clock
      @(posedge core_clk);
      mem_wr_req <= 1'b1;
      io_wr_req <= 1'b1;
      len = 0;
      lo = 0;
      repeat (320) begin
         @(posedge core_clk);
         #1;
         if (mem_wr_n === 1'b0 && io_wr_n === 1'b0) len++;
         if ((mem_wr_n !== 1'b1 || io_wr_n !== 1'b1) && proc_clk !== 1'b0) lo++;
      end
      check("strobe_high_phase", 16'(lo), 16'd0);
      check("strobe_seen", len > 0, 1'b1);
      @(posedge core_clk);
      mem_wr_req <= 1'b0;
      io_wr_req <= 1'b0;
      wait_cyc(20);
      measure(64, pr, pe, cr, lo);
      check("strobe_idle", {mem_wr_n, io_wr_n}, 2'h3);
      $display("Test waits and strobes done");
      // Clock output pin sources
      for (int s = 0; s < 4; s++) begin
         wr_reg(8'h0e, 8'(s << 6));
         wait_cyc(10);
         measure(640, pr, pe, cr, lo);
         check("clk_pin_rises", near(cr, exp_cr[s]), 1'b1);
         if (s > 1) check("clk_pin_level", clk_pin, s[0]);
      end
      // Status and buffer enable pin sources, each input against its neighbour
      for (int s = 0; s < 4; s++) begin
         wr_reg(8'h0e, 8'((s << 4) | s));
         for (int p = 0; p < 2; p++) begin
            @(posedge core_clk);
            first_fetch <= p[0];
            int_ack <= ~p[0];
            ext_io_cycle <= p[0];
            data_mem_access <= ~p[0];
            wait_cyc(3);
            #1;
            e = (s == 0) ? ~p[0] : (s == 1) ? p[0] : s[0];
            check("status_n", status_n, e);
            check("buffer_enable_n", buffer_enable_n, e);
         end
      end
      $display("Test output pins done");
      // Watchdog pin follows the timeout, then the override pulse
      wr_reg(8'h0e, 8'h00);
      wdt_timeout_n <= 1'b0;
      wait_cyc(3);
      #1 check("wdo_follow_low", watchdog_out_n, 1'b0);
      @(posedge core_clk);
      wdt_timeout_n <= 1'b1;
      wait_cyc(3);
      #1 check("wdo_follow_high", watchdog_out_n, 1'b1);
      wr_reg(8'h0e, 8'h08);
      len = 0;
      while (watchdog_out_n !== 1'b0 && len < 10) begin
         @(posedge core_clk);
         #1 len++;
      end
      check("wdo_forced", watchdog_out_n, 1'b0);
      rd_reg(8'h0e, d);
      check("override_busy", d, 8'h08);
      len = 3;
      while (watchdog_out_n === 1'b0 && len < 300) begin
         @(posedge core_clk);
         #1 len++;
      end
      check("wdo_low_len", len >= 64 && len <= 130, 1'b1);
      rd_reg(8'h0e, d);
      check("override_clear", d, 8'h00);
      $display("Test watchdog pin done");
      summarize();
   end
endmodule : tb_cdo_clock_ctrl

//--- include/cdo_pkg.sv
// Shared constants, layouts and helpers for the clock doubler and output pin control block
package cdo_pkg;

   // Register offsets on the internal I/O port
   localparam logic [7:0] OFF_PIN_SEL   = 8'h0e;
   localparam logic [7:0] OFF_DBL_DELAY = 8'h0f;
   localparam logic [7:0] OFF_PWR_CTRL  = 8'h10;
   localparam logic [7:0] OFF_STATUS    = 8'h11;

   // Field positions
   localparam int CLKPIN_LSB = 6;
   localparam int STAT_LSB   = 4;
   localparam int WDO_BIT    = 3;
   localparam int BUFFER_ENABLE_N_LSB  = 0;
   localparam int WS_LSB     = 0;
   localparam int CSEL_LSB   = 2;
   localparam int QUART_BIT  = 5;

   // Values after reset
   localparam logic [2:0] RST_DBL_CODE = 3'h0;
   localparam logic [1:0] RST_PIN_SEL  = 2'h0;
   localparam logic [2:0] RST_CLK_SEL  = 3'h2;
   localparam logic [1:0] RST_WS       = 2'h0;

   // Doubler low time: base plus step per code, at the core clock rate
   localparam int CLK_MHZ      = 100;
   localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
   localparam int DBL_BASE_NS  = 6;
   localparam int DBL_STEP_NS  = 2;
   localparam int K32_EDGES_MAX = 2;

   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cdo_bus_req_t;

   // Least time rounds up to whole cycles
   function automatic logic [1:0] dly_cycles(input logic [2:0] code);
      int ns;
      ns = DBL_BASE_NS + DBL_STEP_NS * int'(code);
      return 2'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   endfunction : dly_cycles

   // Fetch wait code 0..3 to 0, 1, 2 or 4 cycles
   function automatic logic [2:0] ws_cycles(input logic [1:0] code);
      return (code == 2'h3) ? 3'h4 : {1'b0, code};
   endfunction : ws_cycles

   // Four-way pin source select shared by three pins
   function automatic logic pin_mux(input logic [1:0] sel, input logic a, input logic b);
      case (sel)
         2'h0:    return a;
         2'h1:    return b;
         2'h2:    return 1'b0;
         default: return 1'b1;
      endcase
   endfunction : pin_mux

endpackage : cdo_pkg

//--- verilog/cdo_clock_ctrl.sv
// Clock doubler, clock dividers, power options and alternate output pin control
//
// Behaviour
// RQ1 - Delay register bits 7:3 are not stored and never affect clocks.
// RQ2 - Delay code zero turns doubling off; the plain oscillator clock passes.
// RQ3 - Codes one to seven double with low time 8 ns to 20 ns, 2 ns steps.
// RQ4 - Software picks the code from oscillator frequency; higher frequency, smaller code.
// RQ5 - Doubled clock is oscillator xor its delayed inverted copy: low pulse per edge.
// RQ6 - Undivided doubled clock is asymmetric; its low phase equals the programmed delay.
// RQ7 - Only memory and I/O write strobes follow the falling clock edge.
// RQ8 - Fetch wait states are programmable to zero, one, two or four.
// RQ9 - With doubler off, processor and peripheral clocks can be divided by four.
// RQ10 - Turning an active doubler off halves processor and peripheral clocks.
// RQ11 - Divide by eight applies to processor clock, peripheral clock or both; the code offers processor only or both.
// RQ12 - Both clocks can run from the 32 kHz oscillator; main oscillator may stop.
// RQ13 - Clock pin: peripheral clock, its half, constant low or constant high.
// RQ14 - Status pin low on opcode fetch, interrupt acknowledge, forced low or high.
// RQ15 - Watchdog pin follows timeout unless override bit drives it low.
// RQ16 - Override low lasts one to two 32 kHz clock cycles.
// RQ17 - Output control bit two is ignored.
// RQ18 - Buffer enable low on external I/O, data memory, forced low or high.
// RQ19 - Doubling plus divide by eight yields net divide by four.
// RQ20 - Reset clears delay code; settings apply at a cycle boundary, no runts.
`timescale 1ns/1ns

module cdo_clock_ctrl #(
   parameter int DLY_DEPTH = 4                     // Oscillator history taps
) (
   input  wire logic                 core_clk,        // Core clock, 100 MHz
   input  wire logic                 reset,           // Synchronous reset, active high
   input  wire cdo_pkg::cdo_bus_req_t reg_req,        // Register bus request
   output logic [7:0]                reg_rdata,       // Read data, cycle after read
   input  wire logic                 osc_main,        // Main oscillator level
   input  wire logic                 osc_32k,         // 32 kHz oscillator level
   input  wire logic                 wdt_timeout_n,   // Watchdog timeout pulse, low
   input  wire logic                 first_fetch,     // First opcode byte fetch
   input  wire logic                 int_ack,         // Interrupt acknowledge cycle
   input  wire logic                 ext_io_cycle,    // External I/O cycle
   input  wire logic                 data_mem_access, // Data memory access
   input  wire logic                 mem_wr_req,      // Memory write in progress
   input  wire logic                 io_wr_req,       // I/O write in progress
   output logic                      proc_clk,        // Processor clock level
   output logic                      peri_clk,        // Peripheral clock level
   output logic                      clk_pin,         // Clock output pin
   output logic                      status_n,        // Status pin, active low
   output logic                      watchdog_out_n,  // Watchdog output pin, low
   output logic                      buffer_enable_n, // Buffer enable pin, low
   output logic                      mem_wr_n,        // Memory write strobe, low
   output logic                      io_wr_n,         // I/O write strobe, low
   output logic [2:0]                fetch_waits,     // Wait states per fetch
   output logic                      main_osc_off     // Main oscillator stop request
);

   // Whole state of the block
   typedef struct packed {
      logic [2:0]           dbl_code;
      logic [2:0]           dbl_act;
      logic [1:0]           clkpin_sel;
      logic [1:0]           stat_sel;
      logic [1:0]           buffer_enable_n_sel;
      logic [1:0]           fetch_ws;
      logic [2:0]           clk_sel;
      logic [2:0]           clk_sel_act;
      logic                 quarter;
      logic                 quarter_act;
      logic [DLY_DEPTH-1:0] osc_hist;
      logic                 src_prev;
      logic [2:0]           div_cnt;
      logic                 peri_prev;
      logic                 peri_half;
      logic                 k32_prev;
      logic [1:0]           k32_edges;
      logic                 wdo_forcing;
      logic [7:0]           rdata;
      logic                 proc_clk;
      logic                 peri_clk;
      logic                 clk_pin;
      logic                 status_n;
      logic                 wdo_n;
      logic                 buffer_enable_n_n;
      logic                 mem_wr_n;
      logic                 io_wr_n;
      logic [2:0]           fetch_waits;
      logic                 osc_off;
   } cdo_state_t;

   cdo_state_t st_ff;
   cdo_state_t nxt_st;

   logic [1:0] dly;
   logic       osc_dly;
   logic       dbl_clk;
   logic       src;
   logic       src_rise;
   logic       on_32k;
   logic       div_slow;
   logic       k32_rise;
   logic       peri_rise;
   logic       wr_pin;
   logic       wr_dbl;
   logic       wr_pwr;

   // Next-state logic
   always_comb begin
      nxt_st = st_ff;

      // Register decode
      wr_pin = reg_req.wr && (reg_req.addr == cdo_pkg::OFF_PIN_SEL);
      wr_dbl = reg_req.wr && (reg_req.addr == cdo_pkg::OFF_DBL_DELAY);
      wr_pwr = reg_req.wr && (reg_req.addr == cdo_pkg::OFF_PWR_CTRL);

      // Only the low three bits are kept
      if (wr_dbl) begin
         nxt_st.dbl_code = reg_req.wdata[2:0];   // RQ1
      end

      // Bit two is dropped on the floor
      if (wr_pin) begin
         nxt_st.clkpin_sel = reg_req.wdata[cdo_pkg::CLKPIN_LSB +: 2];
         nxt_st.stat_sel   = reg_req.wdata[cdo_pkg::STAT_LSB +: 2];
         nxt_st.buffer_enable_n_sel  = reg_req.wdata[cdo_pkg::BUFFER_ENABLE_N_LSB +: 2];   // RQ17
      end

      // Power controls
      if (wr_pwr) begin
         nxt_st.fetch_ws = reg_req.wdata[cdo_pkg::WS_LSB +: 2];     // RQ8
         nxt_st.clk_sel  = reg_req.wdata[cdo_pkg::CSEL_LSB +: 3];   // RQ11 RQ12
         nxt_st.quarter  = reg_req.wdata[cdo_pkg::QUART_BIT];       // RQ9
      end
      nxt_st.fetch_waits = cdo_pkg::ws_cycles(st_ff.fetch_ws);     // RQ8

      // Delayed copy of the oscillator; code selects the tap
      nxt_st.osc_hist = {st_ff.osc_hist[DLY_DEPTH-2:0], osc_main};
      dly     = cdo_pkg::dly_cycles(st_ff.dbl_act);                 // RQ3
      osc_dly = st_ff.osc_hist[dly - 2'h1];

      // Xor with inverted delayed copy: low for the delay after each edge
      dbl_clk = osc_main ^ ~osc_dly;                                // RQ5 RQ6

      // Source select; 32 kHz bypasses the doubler
      on_32k = st_ff.clk_sel_act[2];
      if (on_32k) begin
         src = osc_32k;                                             // RQ12
      end else if (st_ff.dbl_act != 3'h0) begin
         src = dbl_clk;                                             // RQ3
      end else begin
         src = osc_main;                                            // RQ2 RQ10
      end

      // Edge counter feeds the dividers
      src_rise = src && !st_ff.src_prev;
      nxt_st.src_prev = src;
      if (src_rise) begin
         nxt_st.div_cnt = 3'(st_ff.div_cnt + 3'h1);
      end

      // Settings move over only at a whole divided period, so no runt pulses
      if (src_rise && (st_ff.div_cnt == 3'h7)) begin
         nxt_st.dbl_act     = st_ff.dbl_code;                       // RQ20
         nxt_st.clk_sel_act = st_ff.clk_sel;                        // RQ20
         nxt_st.quarter_act = st_ff.quarter;                        // RQ20
      end

      // Quarter rate only when the doubler is idle
      div_slow = st_ff.div_cnt[2];                                  // RQ11 RQ19
      if (st_ff.quarter_act && (st_ff.dbl_act == 3'h0) && !on_32k) begin
         nxt_st.proc_clk = st_ff.div_cnt[1];                        // RQ9
         nxt_st.peri_clk = st_ff.div_cnt[1];                        // RQ9
      end else if (on_32k) begin
         nxt_st.proc_clk = src;                                     // RQ12
         nxt_st.peri_clk = src;
      end else begin
         case (st_ff.clk_sel_act[1:0])
            2'h0: begin
               nxt_st.proc_clk = div_slow;                          // RQ11
               nxt_st.peri_clk = div_slow;
            end
            2'h1: begin
               nxt_st.proc_clk = div_slow;                          // RQ11
               nxt_st.peri_clk = src;
            end
            default: begin
               nxt_st.proc_clk = src;                               // RQ6
               nxt_st.peri_clk = src;
            end
         endcase
      end

      // Main oscillator stops only after the 32 kHz switch is in effect
      nxt_st.osc_off = on_32k && st_ff.clk_sel_act[0];              // RQ12

      // Halved peripheral clock for the pin, lower emissions
      peri_rise = st_ff.peri_clk && !st_ff.peri_prev;
      nxt_st.peri_prev = st_ff.peri_clk;
      if (peri_rise) begin
         nxt_st.peri_half = !st_ff.peri_half;
      end
      nxt_st.clk_pin = cdo_pkg::pin_mux(st_ff.clkpin_sel, st_ff.peri_clk, st_ff.peri_half);  // RQ13

      // Status and buffer enable pins
      nxt_st.status_n = cdo_pkg::pin_mux(st_ff.stat_sel, !first_fetch, !int_ack);            // RQ14
      nxt_st.buffer_enable_n_n  = cdo_pkg::pin_mux(st_ff.buffer_enable_n_sel, !ext_io_cycle, !data_mem_access);  // RQ18

      // Watchdog override ends on the second 32 kHz rising edge
      k32_rise = osc_32k && !st_ff.k32_prev;
      nxt_st.k32_prev = osc_32k;
      if (wr_pin && reg_req.wdata[cdo_pkg::WDO_BIT]) begin
         nxt_st.wdo_forcing = 1'b1;                                 // RQ15
         nxt_st.k32_edges   = 2'h0;
      end else if (st_ff.wdo_forcing && k32_rise) begin
         nxt_st.k32_edges = 2'(st_ff.k32_edges + 2'h1);
         if (st_ff.k32_edges == 2'(cdo_pkg::K32_EDGES_MAX - 1)) begin
            nxt_st.wdo_forcing = 1'b0;                              // RQ16
         end
      end
      nxt_st.wdo_n = !st_ff.wdo_forcing && wdt_timeout_n;           // RQ15

      // Write strobes live in the low phase, after the falling edge
      nxt_st.mem_wr_n = !(mem_wr_req && !nxt_st.proc_clk);          // RQ7
      nxt_st.io_wr_n  = !(io_wr_req && !nxt_st.proc_clk);           // RQ7

      // Read data stands for one cycle only
      nxt_st.rdata = 8'h00;
      if (reg_req.rd) begin
         case (reg_req.addr)
            cdo_pkg::OFF_PIN_SEL:   nxt_st.rdata = {st_ff.clkpin_sel, st_ff.stat_sel,
                                                    st_ff.wdo_forcing, 1'b0, st_ff.buffer_enable_n_sel};
            cdo_pkg::OFF_DBL_DELAY: nxt_st.rdata = {5'h00, st_ff.dbl_code};
            cdo_pkg::OFF_PWR_CTRL:  nxt_st.rdata = {2'h0, st_ff.quarter, st_ff.clk_sel, st_ff.fetch_ws};
            cdo_pkg::OFF_STATUS:    nxt_st.rdata = {st_ff.wdo_forcing, st_ff.proc_clk,
                                                    st_ff.clk_sel_act, st_ff.dbl_act};
            default:                nxt_st.rdata = 8'h00;
         endcase
      end
   end

   // State register; reset starts with the doubler off
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_ff             <= '0;
         st_ff.dbl_code    <= cdo_pkg::RST_DBL_CODE;                // RQ20
         st_ff.dbl_act     <= cdo_pkg::RST_DBL_CODE;                // RQ20
         st_ff.clkpin_sel  <= cdo_pkg::RST_PIN_SEL;
         st_ff.stat_sel    <= cdo_pkg::RST_PIN_SEL;
         st_ff.buffer_enable_n_sel   <= cdo_pkg::RST_PIN_SEL;
         st_ff.fetch_ws    <= cdo_pkg::RST_WS;
         st_ff.clk_sel     <= cdo_pkg::RST_CLK_SEL;
         st_ff.clk_sel_act <= cdo_pkg::RST_CLK_SEL;
         st_ff.status_n    <= 1'b1;
         st_ff.wdo_n       <= 1'b1;
         st_ff.buffer_enable_n_n     <= 1'b1;
         st_ff.mem_wr_n    <= 1'b1;
         st_ff.io_wr_n     <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state flops
   assign reg_rdata       = st_ff.rdata;
   assign proc_clk        = st_ff.proc_clk;
   assign peri_clk        = st_ff.peri_clk;
   assign clk_pin         = st_ff.clk_pin;
   assign status_n        = st_ff.status_n;
   assign watchdog_out_n  = st_ff.wdo_n;
   assign buffer_enable_n = st_ff.buffer_enable_n_n;
   assign mem_wr_n        = st_ff.mem_wr_n;
   assign io_wr_n         = st_ff.io_wr_n;
   assign fetch_waits     = st_ff.fetch_waits;
   assign main_osc_off    = st_ff.osc_off;

   // Upper delay bits never reach the stored code
   property p_dbl_low_bits;
      @(posedge core_clk) disable iff (reset)
      (reg_req.wr && reg_req.addr == cdo_pkg::OFF_DBL_DELAY)
         |=> (st_ff.dbl_code == $past(reg_req.wdata[2:0]));
   endproperty
   a_dbl_low_bits: assert property (p_dbl_low_bits) else $error("delay code not stored from low bits");  // RQ1

   // Doubler off: processor clock tracks the oscillator
   property p_dbl_off_pass;
      @(posedge core_clk) disable iff (reset)
      (st_ff.dbl_act == 3'h0 && st_ff.clk_sel_act[2:1] == 2'h1 && !st_ff.quarter_act)
         |=> (st_ff.proc_clk == $past(osc_main));
   endproperty
   a_dbl_off_pass: assert property (p_dbl_off_pass) else $error("undoubled clock not passed");  // RQ2

   // Each oscillator edge opens a low pulse
   property p_dbl_low_pulse;
      @(posedge core_clk) disable iff (reset)
      (st_ff.dbl_act != 3'h0 && st_ff.clk_sel_act[2:1] == 2'h1
         && osc_main != st_ff.osc_hist[0] && st_ff.osc_hist[0] == st_ff.osc_hist[1])
         |=> !st_ff.proc_clk;
   endproperty
   a_dbl_low_pulse: assert property (p_dbl_low_pulse) else $error("no low pulse after oscillator edge");  // RQ5

   // Write strobe only in the clock low phase
   property p_wr_low_phase;
      @(posedge core_clk) disable iff (reset)
      (!mem_wr_n || !io_wr_n) |-> (!proc_clk && $past(mem_wr_req || io_wr_req));
   endproperty
   a_wr_low_phase: assert property (p_wr_low_phase) else $error("write strobe outside low phase");  // RQ7

   // Fetch waits decode two cycles after the write
   property p_fetch_waits;
      @(posedge core_clk) disable iff (reset)
      (reg_req.wr && reg_req.addr == cdo_pkg::OFF_PWR_CTRL)
         |=> ##1 (fetch_waits == cdo_pkg::ws_cycles($past(reg_req.wdata[1:0], 2)));
   endproperty
   a_fetch_waits: assert property (p_fetch_waits) else $error("wrong fetch wait count");  // RQ8

   // Clock pin forced low
   property p_clkpin_low;
      @(posedge core_clk) disable iff (reset)
      (st_ff.clkpin_sel == 2'h2) |=> !clk_pin;
   endproperty
   a_clkpin_low: assert property (p_clkpin_low) else $error("clock pin not low");  // RQ13

   // Status pin marks opcode fetches
   property p_status_fetch;
      @(posedge core_clk) disable iff (reset)
      (st_ff.stat_sel == 2'h0 && first_fetch) |=> !status_n;
   endproperty
   a_status_fetch: assert property (p_status_fetch) else $error("status pin missed fetch");  // RQ14

   // Override drives the watchdog pin low
   property p_wdo_force;
      @(posedge core_clk) disable iff (reset)
      (reg_req.wr && reg_req.addr == cdo_pkg::OFF_PIN_SEL && reg_req.wdata[cdo_pkg::WDO_BIT])
         |=> ##1 !watchdog_out_n;
   endproperty
   a_wdo_force: assert property (p_wdo_force) else $error("watchdog pin not forced low");  // RQ15

   // Buffer enable marks data memory accesses
   property p_buffer_enable_n_mem;
      @(posedge core_clk) disable iff (reset)
      (st_ff.buffer_enable_n_sel == 2'h1 && data_mem_access) |=> !buffer_enable_n;
   endproperty
   a_buffer_enable_n_mem: assert property (p_buffer_enable_n_mem) else $error("buffer enable missed data access");  // RQ18

endmodule : cdo_clock_ctrl
